// *** tmc_timer.sv ***
// Sixteen-bit timer/counter with AXI4-Lite registers, interrupt and pin control.
// Assumes all inputs are synchronous to REF_CLK (40 MHz) and RSTN is async.
//
// Summary of operation
// - Count is sixteen bits in two byte registers, both readable and writable.
// - Count increments upward and wraps from all ones back to zero.
// - Every wrap sets the latched overflow flag, bit 0 of the flag register.
// - Overflow flag reaches the interrupt only while enable bit 0 is set.
// - Control bit 1 selects timer or counter operation.
// - Timer mode adds one every core cycle while running.
// - Counter mode adds one per rising edge of the external input.
// - Count advances only while control bit 0 is set, else holds.
// - Either capture/compare/PWM unit may pulse an internal count reset.
// - Oscillator enable forces both oscillator pins to inputs, ignoring direction bits.
`timescale 1ns/10ps
module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic        REF_CLK,      // Core clock, 40 MHz
  input  wire logic        RSTN,         // Async reset, active low
  input  wire logic [7:0]  AWADDR,       // Write address
  input  wire logic        AWVALID,      // Write address valid
  output logic             AWREADY,      // Write address ready
  input  wire logic [31:0] WDATA,        // Write data
  input  wire logic [3:0]  WSTRB,        // Write byte strobes
  input  wire logic        WVALID,       // Write data valid
  output logic             WREADY,       // Write data ready
  output logic [1:0]       BRESP,        // Write response
  output logic             BVALID,       // Write response valid
  input  wire logic        BREADY,       // Write response ready
  input  wire logic [7:0]  ARADDR,       // Read address
  input  wire logic        ARVALID,      // Read address valid
  output logic             ARREADY,      // Read address ready
  output logic [31:0]      RDATA,        // Read data
  output logic [1:0]       RRESP,        // Read response
  output logic             RVALID,       // Read data valid
  input  wire logic        RREADY,       // Read data ready
  input  wire logic        CCP_RESET_A,  // Count reset from first capture unit
  input  wire logic        CCP_RESET_B,  // Count reset from second capture unit
  input  wire logic        OSC_OUT_I,    // osc_output_pin level, also count input
  output logic             OSC_OUT_O,    // osc_output_pin drive value
  output logic             OSC_OUT_OE,   // osc_output_pin drive enable
  input  wire logic        OSC_IN_I,     // osc_input_pin level
  output logic             OSC_IN_O,     // osc_input_pin drive value
  output logic             OSC_IN_OE,    // osc_input_pin drive enable
  output logic             IRQ           // Level interrupt, active high
);

  // ==========================================================================
  // Write channel: address and data taken in either order
  logic                 aw_ok_r;
  logic                 w_ok_r;
  logic                 aw_full_r;
  logic                 w_full_r;
  logic [7:0]           wr_addr_r;
  logic [REG_WIDTH-1:0] wr_data_r;
  logic                 wr_strb_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 wr_go;
  logic                 wr_hit;

  assign wr_go = aw_full_r & w_full_r & ~bvalid_r;

  // Ready drops on acceptance and reopens once the response is gone
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_ok_r <= 1'b0;
      w_ok_r  <= 1'b0;
    end
    else
    begin
      if (AWVALID && aw_ok_r)
        aw_ok_r <= 1'b0;
      else if (!aw_full_r && !bvalid_r)
        aw_ok_r <= 1'b1;
      if (WVALID && w_ok_r)
        w_ok_r <= 1'b0;
      else if (!w_full_r && !bvalid_r)
        w_ok_r <= 1'b1;
    end
  end

  // Hold address and data until both are present
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      wr_strb_r <= 1'b0;
    end
    else
    begin
      if (AWVALID && aw_ok_r)
      begin
        aw_full_r <= 1'b1;
        wr_addr_r <= AWADDR;
      end
      else if (wr_go)
        aw_full_r <= 1'b0;
      if (WVALID && w_ok_r)
      begin
        w_full_r  <= 1'b1;
        wr_data_r <= WDATA[REG_WIDTH-1:0];  // Only lane 0 carries data
        wr_strb_r <= WSTRB[0];
      end
      else if (wr_go)
        w_full_r <= 1'b0;
    end
  end

  // Decode of the held write address
  always_comb
  begin
    unique case (wr_addr_r)
      ADDR_COUNT_LOW, ADDR_COUNT_HIGH, ADDR_FLAG_REG, ADDR_ENABLE_REG,
      ADDR_CONTROL, ADDR_PORT_DIR, ADDR_PORT_DATA: wr_hit = 1'b1;
      default:                                     wr_hit = 1'b0;
    endcase
  end

  // Response after both halves; unmapped addresses get SLVERR
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (BREADY)
      bvalid_r <= 1'b0;
  end

  // Register write strobes, gated by lane 0 strobe
  logic wr_en;
  logic wr_cnt_lo;
  logic wr_cnt_hi;

  assign wr_en     = wr_go & wr_strb_r;
  assign wr_cnt_lo = wr_en & (wr_addr_r == ADDR_COUNT_LOW);
  assign wr_cnt_hi = wr_en & (wr_addr_r == ADDR_COUNT_HIGH);

  // ==========================================================================
  // Software registers
  logic [CTRL_IMPL_MSB:0] control_r;
  logic                   irq_enable_r;
  logic [PORT_BITS-1:0]   port_dir_r;
  logic [PORT_BITS-1:0]   port_dat_r;

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      control_r    <= CONTROL_RESET[CTRL_IMPL_MSB:0];
      irq_enable_r <= 1'b0;
      port_dir_r   <= PORT_DIR_RESET;
      port_dat_r   <= PORT_DAT_RESET;
    end
    else if (wr_en)
    begin
      if (wr_addr_r == ADDR_CONTROL)
        control_r <= wr_data_r[CTRL_IMPL_MSB:0];
      if (wr_addr_r == ADDR_ENABLE_REG)
        irq_enable_r <= wr_data_r[BIT_OVERFLOW];
      if (wr_addr_r == ADDR_PORT_DIR)
        port_dir_r <= wr_data_r[PORT_BITS-1:0];
      if (wr_addr_r == ADDR_PORT_DATA)
        port_dat_r <= wr_data_r[PORT_BITS-1:0];
    end
  end

  logic run_control;
  logic clock_source_select;
  logic dedicated_osc_enable;

  assign run_control          = control_r[BIT_RUN_CONTROL];
  assign clock_source_select  = control_r[BIT_CLOCK_SELECT];
  assign dedicated_osc_enable = control_r[BIT_OSC_ENABLE];

  // ==========================================================================
  // Count core
  logic [COUNT_WIDTH-1:0] count;
  logic                   wrap;
  logic                   ccp_clear;

  assign ccp_clear = CCP_RESET_A | CCP_RESET_B;

  tmc_count_core #(
    .WIDTH    (COUNT_WIDTH)
  ) u_core (
    .clk      (REF_CLK),
    .rst_n    (RSTN),
    .run      (run_control),
    .ext_mode (clock_source_select),
    .ext_in   (OSC_OUT_I),
    .clr      (ccp_clear),
    .wr_lo    (wr_cnt_lo),
    .wr_hi    (wr_cnt_hi),
    .wr_byte  (wr_data_r),
    .count    (count),
    .wrap     (wrap)
  );

  // ==========================================================================
  // Overflow flag and interrupt; a wrap in the clearing cycle wins
  logic overflow_flag_r;
  logic flag_clear;
  logic irq_r;

  assign flag_clear = wr_en & (wr_addr_r == ADDR_FLAG_REG) & ~wr_data_r[BIT_OVERFLOW];

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      overflow_flag_r <= 1'b0;
    else if (wrap)
      overflow_flag_r <= 1'b1;
    else if (flag_clear)
      overflow_flag_r <= 1'b0;
  end

  // Registered so the output comes straight from a flop
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      irq_r <= 1'b0;
    else
      irq_r <= overflow_flag_r & irq_enable_r;
  end

  // ==========================================================================
  // Pin drive: direction bit 1 means input
  logic osc_out_oe_r;
  logic osc_in_oe_r;
  logic osc_out_o_r;
  logic osc_in_o_r;

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      osc_out_oe_r <= 1'b0;
      osc_in_oe_r  <= 1'b0;
      osc_out_o_r  <= 1'b0;
      osc_in_o_r   <= 1'b0;
    end
    else
    begin
      osc_out_oe_r <= ~dedicated_osc_enable & ~port_dir_r[PIN_OSC_OUT];
      osc_in_oe_r  <= ~dedicated_osc_enable & ~port_dir_r[PIN_OSC_IN];
      osc_out_o_r  <= port_dat_r[PIN_OSC_OUT];
      osc_in_o_r   <= port_dat_r[PIN_OSC_IN];
    end
  end

  // ==========================================================================
  // Read channel: one cycle from address to data
  logic        ar_ok_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_mux;
  logic        rd_hit;

  // Read mux; unused upper bits read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (ARADDR)
      ADDR_COUNT_LOW:  rd_mux[7:0] = count[7:0];
      ADDR_COUNT_HIGH: rd_mux[7:0] = count[COUNT_WIDTH-1:8];
      ADDR_FLAG_REG:   rd_mux[BIT_OVERFLOW] = overflow_flag_r;
      ADDR_ENABLE_REG: rd_mux[BIT_OVERFLOW] = irq_enable_r;
      ADDR_CONTROL:    rd_mux[CTRL_IMPL_MSB:0] = control_r;
      ADDR_PORT_DIR:   rd_mux[PORT_BITS-1:0] = port_dir_r;
      ADDR_PORT_DATA:  rd_mux[PORT_BITS-1:0] = {OSC_IN_I, OSC_OUT_I};  // Pin levels
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      ar_ok_r <= 1'b0;
    else if (ARVALID && ar_ok_r)
      ar_ok_r <= 1'b0;
    else if (!rvalid_r)
      ar_ok_r <= 1'b1;
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (ARVALID && ar_ok_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RREADY)
      rvalid_r <= 1'b0;
  end

  // ==========================================================================
  // Outputs
  assign AWREADY    = aw_ok_r;
  assign WREADY     = w_ok_r;
  assign BVALID     = bvalid_r;
  assign BRESP      = bresp_r;
  assign ARREADY    = ar_ok_r;
  assign RVALID     = rvalid_r;
  assign RDATA      = rdata_r;
  assign RRESP      = rresp_r;
  assign IRQ        = irq_r;
  assign OSC_OUT_OE = osc_out_oe_r;
  assign OSC_IN_OE  = osc_in_oe_r;
  assign OSC_OUT_O  = osc_out_o_r;
  assign OSC_IN_O   = osc_in_o_r;

  // ==========================================================================
  // Checks
  // Count stepping is checked inside the core; flag, interrupt and pins here
  a_wrap_sets_flag: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !ccp_clear && !wr_cnt_lo && !wr_cnt_hi && run_control && !clock_source_select
    && (&count) |-> ##2 overflow_flag_r)
    else $error("overflow flag not set on wrap");

  a_irq_gating: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    ##1 IRQ == $past(overflow_flag_r & irq_enable_r))
    else $error("interrupt does not follow flag and enable");

  a_pins_input: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    dedicated_osc_enable |=> !OSC_OUT_OE && !OSC_IN_OE)
    else $error("oscillator pin driven while oscillator enabled");

  a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    overflow_flag_r && !flag_clear |=> overflow_flag_r)
    else $error("overflow flag dropped without clear");

endmodule : tmc_timer

// *** tmc_pkg.sv ***
// Shared constants for the sixteen-bit timer/counter block.
// Assumes a 32-bit AXI4-Lite register bus and byte-wide registers in lane 0.
package tmc_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;  // count_low_byte
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;  // count_high_byte
  localparam logic [7:0] ADDR_FLAG_REG   = 8'h08;  // peripheral_flag_reg_one
  localparam logic [7:0] ADDR_ENABLE_REG = 8'h0c;  // peripheral_enable_reg_one
  localparam logic [7:0] ADDR_CONTROL    = 8'h10;  // counter_control
  localparam logic [7:0] ADDR_PORT_DIR   = 8'h14;  // port_c_direction
  localparam logic [7:0] ADDR_PORT_DATA  = 8'h18;  // port output latch

  // ==========================================================================
  // Field positions
  localparam int BIT_RUN_CONTROL  = 0;  // counter_control run bit
  localparam int BIT_CLOCK_SELECT = 1;  // counter_control source select
  localparam int BIT_OSC_ENABLE   = 3;  // counter_control oscillator enable
  localparam int CTRL_IMPL_MSB    = 5;  // bits above read as zero
  localparam int BIT_OVERFLOW     = 0;  // flag and enable position
  localparam int PIN_OSC_OUT      = 0;  // port bit of osc_output_pin
  localparam int PIN_OSC_IN       = 1;  // port bit of osc_input_pin

  // ==========================================================================
  // Widths and reset values
  localparam int         REG_WIDTH      = 8;
  localparam int         COUNT_WIDTH    = 16;
  localparam int         PORT_BITS      = 2;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [1:0] PORT_DIR_RESET = 2'h3;   // both pins input after reset
  localparam logic [1:0] PORT_DAT_RESET = 2'h0;

  // ==========================================================================
  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tmc_pkg

// *** tmc_count_core.sv ***
// Sixteen-bit up-count with byte writes, clear input and wrap pulse.
// Assumes the external count input is already synchronous to clk.
`timescale 1ns/10ps
module tmc_count_core
  import tmc_pkg::*;
#(
  parameter int WIDTH = COUNT_WIDTH
)
(
  input  wire logic             clk,       // Core clock
  input  wire logic             rst_n,     // Async reset, active low
  input  wire logic             run,       // Counting enabled
  input  wire logic             ext_mode,  // 1: count external edges
  input  wire logic             ext_in,    // External count input level
  input  wire logic             clr,       // Internal reset input
  input  wire logic             wr_lo,     // Software write of low byte
  input  wire logic             wr_hi,     // Software write of high byte
  input  wire logic [7:0]       wr_byte,   // Byte being written
  output logic      [WIDTH-1:0] count,     // Current count
  output logic                  wrap       // Pulse: count rolled over
);

  // ==========================================================================
  // Edge detection and step decision
  logic             ext_d_r;
  logic             step;
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             wrap_r;

  // Remember last input level for rising-edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ext_d_r <= 1'b0;
    else
      ext_d_r <= ext_in;
  end

  // Timer mode steps every cycle, counter mode on rising edges only
  always_comb
  begin
    step = run & (ext_mode ? (ext_in & ~ext_d_r) : 1'b1);
  end

  // ==========================================================================
  // Count register: clear beats write beats increment
  always_comb
  begin
    count_nxt = count_r;
    if (clr)
      count_nxt = '0;
    else if (wr_lo || wr_hi)
    begin
      if (wr_lo)
        count_nxt[7:0] = wr_byte;
      if (wr_hi)
        count_nxt[WIDTH-1:8] = wr_byte[WIDTH-9:0];
    end
    else if (step)
      count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  // Wrap pulse only for a genuine increment out of all ones
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrap_r <= 1'b0;
    else
      wrap_r <= step & ~clr & ~wr_lo & ~wr_hi & (&count_r);
  end

  assign count = count_r;
  assign wrap  = wrap_r;

  // ==========================================================================
  // Checks; quiet means no clear and no software write in this cycle
  logic quiet;

  assign quiet = ~clr & ~wr_lo & ~wr_hi;

  a_low_byte_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_lo && !clr |=> count_r[7:0] == $past(wr_byte))
    else $error("low byte write not stored");

  a_wrap_to_zero: assert property (@(posedge clk) disable iff (!rst_n)
    quiet && run && !ext_mode && (&count_r) |=> count_r == '0 && wrap_r)
    else $error("count did not wrap to zero");

  a_timer_step: assert property (@(posedge clk) disable iff (!rst_n)
    quiet && run && !ext_mode
    |=> count_r == $past(count_r) + {{(WIDTH-1){1'b0}}, 1'b1})
    else $error("timer mode did not step");

  // Edge rebuilt from the input history, independent of the detector flop
  a_counter_edge: assert property (@(posedge clk) disable iff (!rst_n)
    quiet && run && ext_mode
    |=> count_r == $past(count_r) + {{(WIDTH-1){1'b0}}, $past(ext_in) & ~$past(ext_in, 2)})
    else $error("counter mode step mismatch");

  a_hold_stopped: assert property (@(posedge clk) disable iff (!rst_n)
    quiet && !run |=> $stable(count_r))
    else $error("count moved while stopped");

  a_ccp_clear: assert property (@(posedge clk) disable iff (!rst_n)
    clr |=> count_r == '0)
    else $error("internal reset did not clear count");

endmodule : tmc_count_core

// *** tb_tmc_timer.sv ***
// Self-checking bench for the sixteen-bit timer/counter block.
// Assumes tmc_pkg and tmc_timer are compiled before this file.
`timescale 1ns/10ps
module tb_tmc_timer
  import tmc_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        REF_CLK, RSTN;
  logic [7:0]  AWADDR, ARADDR;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic        CCP_RESET_A, CCP_RESET_B, OSC_OUT_I, OSC_IN_I;
  logic        OSC_OUT_O, OSC_OUT_OE, OSC_IN_O, OSC_IN_OE, IRQ;
  int          failures;
  int          compares;
  time         t_ar;

  // ==========================================================================
  // Design under test
  tmc_timer dut (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .CCP_RESET_A(CCP_RESET_A),
    .CCP_RESET_B(CCP_RESET_B), .OSC_OUT_I(OSC_OUT_I), .OSC_OUT_O(OSC_OUT_O),
    .OSC_OUT_OE(OSC_OUT_OE), .OSC_IN_I(OSC_IN_I), .OSC_IN_O(OSC_IN_O),
    .OSC_IN_OE(OSC_IN_OE), .IRQ(IRQ)
  );

  // 40 MHz core clock
  always #12.5 REF_CLK = ~REF_CLK;

  // ==========================================================================
  // Reporting
  task final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Four-state compare, so an unknown never passes
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One clock edge of a bounded wait; an exhausted wait ends the run
  task step(inout int n);
    @(posedge REF_CLK);
    n++;
    if (n > 200)
    begin
      check(32'h0, 32'h1);
      final_report;
    end
  endtask : step

  // ==========================================================================
  // AXI4-Lite master: address and data offered together, held until taken
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    WSTRB <= 4'h1;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      step(n);
      if (AWVALID && AWREADY)
      begin
        aw_ok = 1'b1;
        AWVALID <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        w_ok = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do step(n); while (!BVALID);
    BREADY <= 1'b0;
    check({30'h0, BRESP}, {30'h0, er});
  endtask : wr

  // Read with rready held until the answer is sampled
  task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do step(n); while (!ARREADY);
    t_ar = $time;
    ARVALID <= 1'b0;
    do step(n); while (!RVALID);
    d = RDATA;
    RREADY <= 1'b0;
    check({30'h0, RRESP}, {30'h0, er});
  endtask : rd

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, RESP_OKAY);
    check(d, exp);
  endtask : rdc

  // Interrupt is registered, so it is polled under a bound
  task wait_irq(input logic e);
    int n;
    n = 0;
    while (IRQ !== e) step(n);
    check({31'h0, IRQ}, {31'h0, e});
  endtask : wait_irq

  // ==========================================================================
  // Scenarios
  task t_reset;
    logic [31:0] d;
    rdc(ADDR_CONTROL, 32'h0);
    rdc(ADDR_COUNT_LOW, 32'h0);
    rdc(ADDR_COUNT_HIGH, 32'h0);
    rdc(ADDR_FLAG_REG, 32'h0);
    rdc(ADDR_ENABLE_REG, 32'h0);
    check({30'h0, OSC_IN_OE, OSC_OUT_OE}, 32'h0);
    rd(8'h40, d, RESP_SLVERR);
    check(d, 32'h0);
    wr(8'h40, 8'h55, RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset

  task t_timer;
    logic [31:0] d1;
    logic [31:0] d2;
    time         t1;
    wr(ADDR_COUNT_HIGH, 8'h12, RESP_OKAY);
    wr(ADDR_COUNT_LOW, 8'h34, RESP_OKAY);
    rdc(ADDR_COUNT_HIGH, 32'h12);
    rdc(ADDR_COUNT_LOW, 32'h34);
    wr(ADDR_CONTROL, 8'h01, RESP_OKAY);
    rd(ADDR_COUNT_LOW, d1, RESP_OKAY);
    t1 = t_ar;
    rd(ADDR_COUNT_LOW, d2, RESP_OKAY);
    // Both reads sample at the same phase, so the gap in cycles is the step
    check({24'h0, d2[7:0] - d1[7:0]}, {24'h0, 8'((t_ar - t1) / 25)});
    wr(ADDR_CONTROL, 8'hff, RESP_OKAY);
    rdc(ADDR_CONTROL, 32'h3f);
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    $display("test timer done");
  endtask : t_timer

  task t_wrap;
    logic [31:0] d;
    int          n;
    wr(ADDR_ENABLE_REG, 8'h01, RESP_OKAY);
    wr(ADDR_COUNT_HIGH, 8'hff, RESP_OKAY);
    wr(ADDR_COUNT_LOW, 8'hf0, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h01, RESP_OKAY);
    wait_irq(1'b1);
    rdc(ADDR_FLAG_REG, 32'h1);
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    rdc(ADDR_COUNT_HIGH, 32'h0);
    wr(ADDR_FLAG_REG, 8'h01, RESP_OKAY);
    rdc(ADDR_FLAG_REG, 32'h1);
    wr(ADDR_FLAG_REG, 8'h00, RESP_OKAY);
    rdc(ADDR_FLAG_REG, 32'h0);
    wait_irq(1'b0);
    // Second wrap with the enable clear: flag sets, interrupt stays low
    wr(ADDR_ENABLE_REG, 8'h00, RESP_OKAY);
    wr(ADDR_COUNT_HIGH, 8'hff, RESP_OKAY);
    wr(ADDR_COUNT_LOW, 8'hf0, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h01, RESP_OKAY);
    d = 32'h0;
    n = 0;
    while (d[0] !== 1'b1)
    begin
      rd(ADDR_FLAG_REG, d, RESP_OKAY);
      step(n);
    end
    check({31'h0, IRQ}, 32'h0);
    wr(ADDR_ENABLE_REG, 8'h01, RESP_OKAY);
    wait_irq(1'b1);
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    wr(ADDR_FLAG_REG, 8'h00, RESP_OKAY);
    wait_irq(1'b0);
    $display("test wrap done");
  endtask : t_wrap

  task t_clear;
    wr(ADDR_COUNT_HIGH, 8'h56, RESP_OKAY);
    wr(ADDR_COUNT_LOW, 8'h78, RESP_OKAY);
    @(posedge REF_CLK);
    CCP_RESET_A <= 1'b1;
    @(posedge REF_CLK);
    CCP_RESET_A <= 1'b0;
    rdc(ADDR_COUNT_LOW, 32'h0);
    rdc(ADDR_COUNT_HIGH, 32'h0);
    // Held clear while running must win over every increment
    wr(ADDR_CONTROL, 8'h01, RESP_OKAY);
    @(posedge REF_CLK);
    CCP_RESET_B <= 1'b1;
    rdc(ADDR_COUNT_LOW, 32'h0);
    rdc(ADDR_COUNT_HIGH, 32'h0);
    @(posedge REF_CLK);
    CCP_RESET_B <= 1'b0;
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    $display("test clear done");
  endtask : t_clear

  task t_counter;
    wr(ADDR_COUNT_LOW, 8'h00, RESP_OKAY);
    wr(ADDR_COUNT_HIGH, 8'h00, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h03, RESP_OKAY);
    repeat (5)
    begin
      repeat (2) @(posedge REF_CLK);
      OSC_OUT_I <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      OSC_OUT_I <= 1'b0;
    end
    rdc(ADDR_COUNT_LOW, 32'h5);
    rdc(ADDR_COUNT_LOW, 32'h5);
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    $display("test counter done");
  endtask : t_counter

  // Enables are registered one cycle late, hence two edges of settling
  task t_pins;
    wr(ADDR_PORT_DIR, 8'h00, RESP_OKAY);
    repeat (2) @(posedge REF_CLK);
    check({30'h0, OSC_IN_OE, OSC_OUT_OE}, 32'h3);
    // Drive latch reaches the pins; reads return pin levels
    wr(ADDR_PORT_DATA, 8'h02, RESP_OKAY);
    OSC_IN_I <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    check({30'h0, OSC_IN_O, OSC_OUT_O}, 32'h2);
    rdc(ADDR_PORT_DATA, 32'h2);
    rdc(ADDR_PORT_DIR, 32'h0);
    OSC_IN_I <= 1'b0;
    wr(ADDR_CONTROL, 8'h08, RESP_OKAY);
    repeat (2) @(posedge REF_CLK);
    check({30'h0, OSC_IN_OE, OSC_OUT_OE}, 32'h0);
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    repeat (2) @(posedge REF_CLK);
    check({30'h0, OSC_IN_OE, OSC_OUT_OE}, 32'h3);
    $display("test pins done");
  endtask : t_pins

  // ==========================================================================
  // Main sequence
  initial
  begin
    {REF_CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 7'h0;
    {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
    {CCP_RESET_A, CCP_RESET_B, OSC_OUT_I, OSC_IN_I} = 4'h0;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge REF_CLK);
    RSTN <= 1'b1;
    t_reset;
    t_timer;
    t_wrap;
    t_clear;
    t_counter;
    t_pins;
    final_report;
  end

endmodule : tb_tmc_timer
